// File: lin_sci_path_enable_ctrl_bench.sv
/*
 * lin_sci_path_enable_ctrl_bench: directed bench for lpe_ctrl over AXI4-Lite.
 * assumes lpe_peer as the shifter side; receive events are driven here directly.
 */
`timescale 1ns/10ps
module lin_sci_path_enable_ctrl_bench;
	import lpe_pkg::*;
	logic        mclk_in = 1'b0;
	logic        rst_in  = 1'b1;
	logic [11:0] aw_addr = 12'h000, ar_addr = 12'h000;
	logic [31:0] w_data  = 32'h0, r_data, rd;
	logic [3:0]  w_strb  = 4'hf;
	logic [1:0]  b_resp, r_resp, rsp;
	logic        aw_vld = 1'b0, w_vld = 1'b0, b_rdy = 1'b0, ar_vld = 1'b0, r_rdy = 1'b0;
	logic        aw_rdy, w_rdy, b_vld, ar_rdy, r_vld;
	logic        tx_wr = 1'b0, halt = 1'b0, rx_start = 1'b0, rx_char = 1'b0, rx_end = 1'b0, rx_err = 1'b0;
	logic        tx_idle, tx_done, tx_load, rx_store, rx_upd, rx_fval, freeze, cnt_run, irq;
	int          n_mismatch = 0, check_count = 0, n_load = 0, n_store = 0, n_upd = 0;

	always #5 mclk_in = ~mclk_in;

	lpe_ctrl i_lpe_ctrl (.mclk_in(mclk_in), .rst_in(rst_in),
		.s_axi_awaddr_in(aw_addr), .s_axi_awvalid_in(aw_vld), .s_axi_awready_out(aw_rdy),
		.s_axi_wdata_in(w_data), .s_axi_wstrb_in(w_strb), .s_axi_wvalid_in(w_vld), .s_axi_wready_out(w_rdy),
		.s_axi_bresp_out(b_resp), .s_axi_bvalid_out(b_vld), .s_axi_bready_in(b_rdy),
		.s_axi_araddr_in(ar_addr), .s_axi_arvalid_in(ar_vld), .s_axi_arready_out(ar_rdy),
		.s_axi_rdata_out(r_data), .s_axi_rresp_out(r_resp), .s_axi_rvalid_out(r_vld), .s_axi_rready_in(r_rdy),
		.tx_buf_wr_in(tx_wr), .tx_shifter_idle_in(tx_idle), .tx_frame_done_in(tx_done), .tx_load_out(tx_load),
		.rx_frame_start_in(rx_start), .rx_char_done_in(rx_char), .rx_frame_end_in(rx_end), .rx_err_in(rx_err),
		.rx_store_out(rx_store), .rx_flag_upd_out(rx_upd), .rx_flag_valid_out(rx_fval),
		.debug_halt_in(halt), .freeze_out(freeze), .cnt_run_out(cnt_run), .irq_out(irq));

	lpe_peer i_lpe_peer (.mclk_in(mclk_in), .rst_in(rst_in), .tx_load_in(tx_load),
		.tx_shifter_idle_out(tx_idle), .tx_frame_done_out(tx_done));

	always @(posedge mclk_in) begin
		if (tx_load === 1'b1) n_load <= n_load + 1;
		if (rx_store === 1'b1) n_store <= n_store + 1;
		if (rx_upd === 1'b1) n_upd <= n_upd + 1;
	end

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
		check_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
		end
	endtask

	task automatic hang(input string msg);
		n_mismatch++;
		$display("[FAIL] %0t timeout %s", $time, msg);
		give_verdict();
	endtask

	// both channels offered together, each dropped at its own handshake edge
	task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
		int  i;
		bit  done;
		done = 0;
		aw_addr <= a;
		w_data  <= d;
		aw_vld  <= 1'b1;
		w_vld   <= 1'b1;
		b_rdy   <= 1'b1;
		for (i = 0; i < 60 && !done; i++) begin
			@(posedge mclk_in);
			if (aw_vld && aw_rdy === 1'b1) aw_vld <= 1'b0;
			if (w_vld && w_rdy === 1'b1) w_vld <= 1'b0;
			if (b_vld === 1'b1) begin
				done  = 1;
				r     = b_resp;
				b_rdy <= 1'b0;
			end
		end
		if (!done) hang("write");
		repeat (2) @(posedge mclk_in);
	endtask

	task automatic axi_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
		int  i;
		bit  done;
		done = 0;
		ar_addr <= a;
		ar_vld  <= 1'b1;
		r_rdy   <= 1'b1;
		for (i = 0; i < 60 && !done; i++) begin
			@(posedge mclk_in);
			if (ar_vld && ar_rdy === 1'b1) ar_vld <= 1'b0;
			if (r_vld === 1'b1) begin
				done  = 1;
				d     = r_data;
				r     = r_resp;
				r_rdy <= 1'b0;
			end
		end
		if (!done) hang("read");
		@(posedge mclk_in);
	endtask

	task automatic pulse_tx();
		tx_wr <= 1'b1;
		@(posedge mclk_in);
		tx_wr <= 1'b0;
		@(posedge mclk_in);
	endtask

	// order: frame start, character done, frame end, error
	task automatic rx_pulse(input logic [3:0] v);
		{rx_start, rx_char, rx_end, rx_err} <= v;
		@(posedge mclk_in);
		{rx_start, rx_char, rx_end, rx_err} <= 4'h0;
		repeat (3) @(posedge mclk_in);
	endtask

	task automatic wait_load(input int exp);
		int i;
		for (i = 0; i < 200 && n_load < exp; i++) @(posedge mclk_in);
		if (n_load < exp) hang("transmit load");
	endtask

	initial begin
		repeat (12) @(posedge mclk_in);
		rst_in <= 1'b0;
		@(posedge mclk_in);
		axi_rd(OFS_GC1, rd, rsp);
		chk(rd, 32'h0, "control reset value");
		axi_rd(OFS_IRQ_MSK, rd, rsp);
		chk(rd, {28'h0, IRQ_MSK_RST}, "mask reset value");
		axi_wr(OFS_GC1, 32'hffff_ffff, rsp);
		chk(rsp, RESP_OKAY, "control write response");
		axi_rd(OFS_GC1, rd, rsp);
		chk(rd, GC1_WMASK, "control unused bits");
		axi_wr(OFS_GC1, 32'h0, rsp);
		w_strb <= 4'h4;
		axi_wr(OFS_GC1, 32'hffff_ffff, rsp);
		axi_rd(OFS_GC1, rd, rsp);
		chk(rd, 32'h0002_0000, "only the written byte lane lands");
		w_strb <= 4'hf;
		axi_wr(OFS_GC1, 32'h0, rsp);
		axi_wr(12'h0f0, 32'hffff_ffff, rsp);
		chk(rsp, RESP_SLVERR, "unmapped write response");
		axi_rd(12'h0f0, rd, rsp);
		chk(rd, 32'h0, "unmapped read data");
		chk(rsp, RESP_SLVERR, "unmapped read response");
		$display("test registers done");
		// data written while disabled must stay dropped after enabling
		pulse_tx();
		repeat (10) @(posedge mclk_in);
		chk(n_load, 0, "load while disabled");
		axi_wr(OFS_GC1, 32'h0200_0000, rsp);
		repeat (30) @(posedge mclk_in);
		chk(n_load, 0, "early data sent");
		pulse_tx();
		wait_load(1);
		pulse_tx();
		axi_wr(OFS_GC1, 32'h0, rsp);
		wait_load(2);
		repeat (30) @(posedge mclk_in);
		pulse_tx();
		repeat (30) @(posedge mclk_in);
		chk(n_load, 2, "load after frame with enable low");
		$display("test transmit done");
		axi_wr(OFS_IRQ_STS, 32'hf, rsp);
		axi_wr(OFS_GC1, 32'h0100_0000, rsp);
		rx_pulse(4'b1000);
		rx_pulse(4'b0100);
		chk(n_store, 1, "store while enabled");
		chk(n_upd, 1, "flag update while enabled");
		chk(rx_fval, 1, "flags valid for early enable");
		axi_wr(OFS_GC1, 32'h0, rsp);
		rx_pulse(4'b0100);
		rx_pulse(4'b0010);
		chk(n_store, 1, "store after disable mid frame");
		rx_pulse(4'b0001);
		axi_rd(OFS_IRQ_STS, rd, rsp);
		chk(rd & 32'h6, 32'h2, "receive status while disabled");
		chk(n_upd, 1, "flag update while disabled");
		rx_pulse(4'b1000);
		axi_wr(OFS_GC1, 32'h0100_0000, rsp);
		rx_pulse(4'b0100);
		rx_pulse(4'b0010);
		chk(n_store, 2, "store after late enable");
		chk(rx_fval, 0, "flags of late enabled frame");
		$display("test receive done");
		chk(irq, 0, "interrupt fully masked");
		axi_wr(OFS_IRQ_MSK, 32'h2, rsp);
		chk(irq, 1, "unmasked store interrupt");
		axi_wr(OFS_IRQ_STS, 32'h2, rsp);
		chk(irq, 0, "store interrupt cleared");
		axi_wr(OFS_IRQ_MSK, 32'h4, rsp);
		rx_pulse(4'b0001);
		chk(irq, 1, "error interrupt while enabled");
		axi_wr(OFS_IRQ_STS, 32'h4, rsp);
		chk(irq, 0, "error interrupt cleared");
		axi_wr(OFS_IRQ_MSK, 32'h0, rsp);
		$display("test interrupt done");
		axi_wr(OFS_GC1, 32'h0202_0000, rsp);
		chk({freeze, cnt_run}, 2'b01, "continue bit without halt");
		halt <= 1'b1;
		repeat (3) @(posedge mclk_in);
		chk(cnt_run, 1, "counters on suspend with continue");
		chk(freeze, 1, "idle paths stop after drain");
		halt <= 1'b0;
		repeat (3) @(posedge mclk_in);
		axi_wr(OFS_GC1, 32'h0200_0000, rsp);
		chk({freeze, cnt_run}, 2'b01, "no halt no freeze");
		halt <= 1'b1;
		repeat (3) @(posedge mclk_in);
		chk({freeze, cnt_run}, 2'b10, "frozen on suspend");
		pulse_tx();
		repeat (30) @(posedge mclk_in);
		chk(n_load, 2, "load while frozen");
		axi_rd(OFS_PATH, rd, rsp);
		chk(rd, 32'h0000_0009, "path state while frozen");
		chk(rsp, RESP_OKAY, "path read response");
		halt <= 1'b0;
		wait_load(3);
		chk({freeze, cnt_run}, 2'b01, "resumed after suspend");
		axi_wr(OFS_GC1, 32'h0202_0000, rsp);
		halt <= 1'b1;
		repeat (2) @(posedge mclk_in);
		chk(freeze, 0, "keeps running during frame");
		pulse_tx();
		wait_load(4);
		repeat (40) @(posedge mclk_in);
		chk({freeze, cnt_run}, 2'b11, "stopped after drain");
		halt <= 1'b0;
		$display("test suspend done");
		give_verdict();
	end
endmodule // lin_sci_path_enable_ctrl_bench

// File: lpe_axil.sv
/*
 * lpe_axil: AXI4-Lite slave front end, one write and one read in flight.
 * assumes the register decode behind it answers reads combinationally from rd_addr_out.
 */
`timescale 1ns/10ps
module lpe_axil (
	// clock and reset
	input  wire logic                    mclk_in,
	input  wire logic                    rst_in,
	// write channels
	input  wire logic [11:0]             s_axi_awaddr_in,
	input  wire logic                    s_axi_awvalid_in,
	output logic                         s_axi_awready_out,
	input  wire logic [31:0]             s_axi_wdata_in,
	input  wire logic [3:0]              s_axi_wstrb_in,
	input  wire logic                    s_axi_wvalid_in,
	output logic                         s_axi_wready_out,
	output logic [1:0]                   s_axi_bresp_out,
	output logic                         s_axi_bvalid_out,
	input  wire logic                    s_axi_bready_in,
	// read channels
	input  wire logic [11:0]             s_axi_araddr_in,
	input  wire logic                    s_axi_arvalid_in,
	output logic                         s_axi_arready_out,
	output logic [31:0]                  s_axi_rdata_out,
	output logic [1:0]                   s_axi_rresp_out,
	output logic                         s_axi_rvalid_out,
	input  wire logic                    s_axi_rready_in,
	// register side
	output lpe_pkg::lpe_wr_s             wr_out,
	output logic                         wr_vld_out,
	output logic [11:0]                  rd_addr_out,
	input  wire logic [31:0]             rd_data_in
);
	import lpe_pkg::*;

	logic aw_have_r;
	logic w_have_r;
	logic ar_have_r;
	logic aw_take;
	logic w_take;
	logic ar_take;
	logic commit;
	logic rvalid_nxt;

	assign aw_take    = s_axi_awvalid_in & s_axi_awready_out;
	assign w_take     = s_axi_wvalid_in & s_axi_wready_out;
	assign ar_take    = s_axi_arvalid_in & s_axi_arready_out;
	assign commit     = aw_have_r & w_have_r & ~s_axi_bvalid_out;
	assign rvalid_nxt = ar_have_r | (s_axi_rvalid_out & ~s_axi_rready_in);

	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			aw_have_r         <= 1'h0;
			w_have_r          <= 1'h0;
			s_axi_awready_out <= 1'h0;
			s_axi_wready_out  <= 1'h0;
			s_axi_bvalid_out  <= 1'h0;
			s_axi_bresp_out   <= RESP_OKAY;
			wr_out            <= '0;
			wr_vld_out        <= 1'h0;
		end else begin
			aw_have_r         <= (aw_have_r | aw_take) & ~commit;
			w_have_r          <= (w_have_r | w_take) & ~commit;
			s_axi_awready_out <= ~((aw_have_r | aw_take) & ~commit);
			s_axi_wready_out  <= ~((w_have_r | w_take) & ~commit);
			if (aw_take) begin
				wr_out.addr <= s_axi_awaddr_in;
			end
			if (w_take) begin
				wr_out.data <= s_axi_wdata_in;
				wr_out.strb <= s_axi_wstrb_in;
			end
			wr_vld_out <= commit;
			if (commit) begin
				s_axi_bvalid_out <= 1'h1;
				s_axi_bresp_out  <= lpe_addr_hit(wr_out.addr) ? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_bready_in) begin
				s_axi_bvalid_out <= 1'h0;
			end
		end
	end

	// the read address is held so the decode behind it stays stable for the capture
	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			ar_have_r         <= 1'h0;
			s_axi_arready_out <= 1'h0;
			s_axi_rvalid_out  <= 1'h0;
			s_axi_rdata_out   <= '0;
			s_axi_rresp_out   <= RESP_OKAY;
			rd_addr_out       <= '0;
		end else begin
			ar_have_r         <= ar_take;
			s_axi_arready_out <= ~ar_take & ~ar_have_r & ~rvalid_nxt;
			s_axi_rvalid_out  <= rvalid_nxt;
			if (ar_take) begin
				rd_addr_out <= s_axi_araddr_in;
			end
			if (ar_have_r) begin
				s_axi_rdata_out <= lpe_addr_hit(rd_addr_out) ? rd_data_in : 32'h0000_0000;
				s_axi_rresp_out <= lpe_addr_hit(rd_addr_out) ? RESP_OKAY : RESP_SLVERR;
			end
		end
	end
endmodule // lpe_axil

// File: lpe_ctrl.sv
/*
 * lpe_ctrl: transmit/receive path enables, continue-on-suspend and the transfer gates they steer.
 * assumes shifters, buffers and the debug halt level are synchronous to mclk_in.
 */
// Function
// - unused control bits 31-26 and 23-18 read zero, writes to them ignored.
// - transmit buffer moves into the transmit shifter only while transmit enable is one.
// - data written while transmit enable is zero is never transmitted.
// - clearing transmit enable mid-frame still sends already written data, checksum included.
// - receive shifter characters reach receive buffers only while receive enable is one.
// - receive enable zero blocks receive status updates, receive and error interrupts.
// - receive shifter keeps assembling characters whatever receive enable says.
// - receive enable cleared before frame end discards that frame's data; the code drops only characters completing after the clear.
// - receive enable set before frame end stores that frame's data on completion; the code hands off each character as it completes, only once enabled.
// - frame already assembling when receive enable set may have inaccurate status flags.
// - continue-on-suspend matters only during emulator suspension, ignored otherwise.
// - during suspension counters run if continue-on-suspend is one, stop if zero.
// - continue-on-suspend zero freezes state, transmission and counters; resumes on leaving.
// - continue-on-suspend one keeps running until current transmit and receive finish.
`timescale 1ns/10ps
module lpe_ctrl (
	// clock and reset
	input  wire logic         mclk_in,
	input  wire logic         rst_in,
	// AXI4-Lite write
	input  wire logic [11:0]  s_axi_awaddr_in,
	input  wire logic         s_axi_awvalid_in,
	output logic              s_axi_awready_out,
	input  wire logic [31:0]  s_axi_wdata_in,
	input  wire logic [3:0]   s_axi_wstrb_in,
	input  wire logic         s_axi_wvalid_in,
	output logic              s_axi_wready_out,
	output logic [1:0]        s_axi_bresp_out,
	output logic              s_axi_bvalid_out,
	input  wire logic         s_axi_bready_in,
	// AXI4-Lite read
	input  wire logic [11:0]  s_axi_araddr_in,
	input  wire logic         s_axi_arvalid_in,
	output logic              s_axi_arready_out,
	output logic [31:0]       s_axi_rdata_out,
	output logic [1:0]        s_axi_rresp_out,
	output logic              s_axi_rvalid_out,
	input  wire logic         s_axi_rready_in,
	// transmit side
	input  wire logic         tx_buf_wr_in,
	input  wire logic         tx_shifter_idle_in,
	input  wire logic         tx_frame_done_in,
	output logic              tx_load_out,
	// receive side
	input  wire logic         rx_frame_start_in,
	input  wire logic         rx_char_done_in,
	input  wire logic         rx_frame_end_in,
	input  wire logic         rx_err_in,
	output logic              rx_store_out,
	output logic              rx_flag_upd_out,
	output logic              rx_flag_valid_out,
	// debug suspension
	input  wire logic         debug_halt_in,
	output logic              freeze_out,
	output logic              cnt_run_out,
	// interrupt
	output logic              irq_out
);
	import lpe_pkg::*;

	lpe_wr_s          wr;
	logic             wr_vld;
	logic [11:0]      rd_addr;
	logic [31:0]      rd_data;
	logic             tx_en_r;
	logic             rx_en_r;
	logic             ros_r;
	logic [IRQ_W-1:0] irq_msk_r;
	logic [IRQ_W-1:0] irq_sts;
	logic [IRQ_W-1:0] irq_set;
	logic [IRQ_W-1:0] irq_clr;
	logic             tx_pend_r;
	logic             tx_act_r;
	logic             rx_act_r;
	logic             tx_go;
	logic             rx_take;
	logic             late_en;
	lpe_susp_e        susp_r;
	lpe_susp_e        susp_nxt;
	logic             wr_gc1;

	lpe_axil u_axil (
		.mclk_in           (mclk_in),
		.rst_in            (rst_in),
		.s_axi_awaddr_in   (s_axi_awaddr_in),
		.s_axi_awvalid_in  (s_axi_awvalid_in),
		.s_axi_awready_out (s_axi_awready_out),
		.s_axi_wdata_in    (s_axi_wdata_in),
		.s_axi_wstrb_in    (s_axi_wstrb_in),
		.s_axi_wvalid_in   (s_axi_wvalid_in),
		.s_axi_wready_out  (s_axi_wready_out),
		.s_axi_bresp_out   (s_axi_bresp_out),
		.s_axi_bvalid_out  (s_axi_bvalid_out),
		.s_axi_bready_in   (s_axi_bready_in),
		.s_axi_araddr_in   (s_axi_araddr_in),
		.s_axi_arvalid_in  (s_axi_arvalid_in),
		.s_axi_arready_out (s_axi_arready_out),
		.s_axi_rdata_out   (s_axi_rdata_out),
		.s_axi_rresp_out   (s_axi_rresp_out),
		.s_axi_rvalid_out  (s_axi_rvalid_out),
		.s_axi_rready_in   (s_axi_rready_in),
		.wr_out            (wr),
		.wr_vld_out        (wr_vld),
		.rd_addr_out       (rd_addr),
		.rd_data_in        (rd_data)
	);

	assign wr_gc1 = wr_vld & (wr.addr[11:2] == OFS_GC1[11:2]);

	// only the three control bits (two enables, continue-on-suspend) hold state; the rest of the word is not stored
	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			tx_en_r <= TX_EN_RST;
			rx_en_r <= RX_EN_RST;
			ros_r   <= ROS_RST;
		end else if (wr_gc1) begin
			if (wr.strb[3]) begin
				tx_en_r <= wr.data[TX_EN_BIT];
				rx_en_r <= wr.data[RX_EN_BIT];
			end
			if (wr.strb[2]) begin
				ros_r <= wr.data[ROS_BIT];
			end
		end
	end

	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			irq_msk_r <= IRQ_MSK_RST;
		end else if (wr_vld && wr.addr[11:2] == OFS_IRQ_MSK[11:2] && wr.strb[0]) begin
			irq_msk_r <= wr.data[IRQ_W-1:0];
		end
	end

	always_comb begin
		rd_data = 32'h0000_0000;
		unique case (rd_addr[11:2])
			OFS_GC1[11:2]: begin
				rd_data[TX_EN_BIT] = tx_en_r;
				rd_data[RX_EN_BIT] = rx_en_r;
				rd_data[ROS_BIT]   = ros_r;
			end
			OFS_IRQ_STS[11:2]: rd_data[IRQ_W-1:0] = irq_sts;
			OFS_IRQ_MSK[11:2]: rd_data[IRQ_W-1:0] = irq_msk_r;
			OFS_PATH[11:2]: begin
				rd_data[PS_TX_PEND] = tx_pend_r;
				rd_data[PS_TX_ACT]  = tx_act_r;
				rd_data[PS_RX_ACT]  = rx_act_r;
				rd_data[PS_FREEZE]  = freeze_out;
				rd_data[PS_FLAG_OK] = rx_flag_valid_out;
				rd_data[PS_CNT_RUN] = cnt_run_out;
			end
			default: rd_data = 32'h0000_0000;
		endcase
	end

	// suspension: drain only when continuing, freeze otherwise
	always_comb begin
		susp_nxt = susp_r;
		unique case (susp_r)
			SUSP_RUN: begin
				if (debug_halt_in) begin
					susp_nxt = ros_r ? SUSP_DRAIN : SUSP_FROZEN;
				end
			end
			SUSP_DRAIN: begin
				if (!debug_halt_in) begin
					susp_nxt = SUSP_RUN;
				end else if (!ros_r || (!tx_act_r && !rx_act_r)) begin
					// dropping the bit mid-drain freezes at once
					susp_nxt = SUSP_FROZEN;
				end
			end
			SUSP_FROZEN: begin
				if (!debug_halt_in) begin
					susp_nxt = SUSP_RUN;
				end
			end
		endcase
	end

	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			susp_r      <= SUSP_RUN;
			freeze_out  <= 1'h0;
			cnt_run_out <= 1'h0;
		end else begin
			susp_r      <= susp_nxt;
			freeze_out  <= (susp_nxt == SUSP_FROZEN);
			cnt_run_out <= ~debug_halt_in | ros_r;
		end
	end

	// a started frame may finish after the enable drops, so the frame keeps its own permission
	assign tx_go = tx_pend_r & ~tx_load_out & tx_shifter_idle_in & (tx_en_r | tx_act_r) &
		((susp_r == SUSP_RUN) | ((susp_r == SUSP_DRAIN) & tx_act_r));

	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			tx_pend_r   <= 1'h0;
			tx_act_r    <= 1'h0;
			tx_load_out <= 1'h0;
		end else begin
			tx_load_out <= tx_go;
			if (tx_buf_wr_in && tx_en_r) begin
				tx_pend_r <= 1'h1;
			end else if (tx_go) begin
				tx_pend_r <= 1'h0;
			end
			if (tx_go) begin
				tx_act_r <= 1'h1;
			end else if (tx_frame_done_in) begin
				tx_act_r <= 1'h0;
			end
		end
	end

	// the shifter assembles regardless; only the hand-off is gated
	assign rx_take = rx_char_done_in & rx_en_r;
	assign late_en = rx_act_r & ~rx_flag_valid_out & wr_gc1 & wr.strb[3] & wr.data[RX_EN_BIT] & ~rx_en_r;

	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			rx_act_r          <= 1'h0;
			rx_store_out      <= 1'h0;
			rx_flag_upd_out   <= 1'h0;
			rx_flag_valid_out <= 1'h0;
		end else begin
			rx_store_out    <= rx_take;
			rx_flag_upd_out <= rx_take;
			if (rx_frame_start_in) begin
				rx_act_r          <= 1'h1;
				rx_flag_valid_out <= rx_en_r;
			end else if (rx_frame_end_in) begin
				rx_act_r <= 1'h0;
			end
		end
	end

	always_comb begin
		irq_set              = '0;
		irq_set[IRQ_TX_LOAD] = tx_go;
		irq_set[IRQ_RX_STOR] = rx_take;
		irq_set[IRQ_RX_ERR]  = rx_err_in & rx_en_r;
		irq_set[IRQ_LATE_EN] = late_en;
		irq_clr              = '0;
		if (wr_vld && wr.addr[11:2] == OFS_IRQ_STS[11:2] && wr.strb[0]) begin
			irq_clr = wr.data[IRQ_W-1:0];
		end
	end

	lpe_w1c #(
		.W (IRQ_W)
	) u_sts (
		.mclk_in (mclk_in),
		.rst_in  (rst_in),
		.set_in  (irq_set),
		.clr_in  (irq_clr),
		.q_out   (irq_sts)
	);

	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			irq_out <= 1'h0;
		end else begin
			irq_out <= |(irq_sts & irq_msk_r);
		end
	end

	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (rst_in);

	property p_rsvd_zero;
		(rd_addr[11:2] == OFS_GC1[11:2]) |-> ((rd_data & ~GC1_WMASK) == 32'h0000_0000);
	endproperty
	a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved control bits read nonzero");

	property p_tx_gate;
		tx_load_out |-> ($past(tx_en_r) || $past(tx_act_r));
	endproperty
	a_tx_gate: assert property (p_tx_gate) else $error("load without transmit enable");

	property p_tx_drop;
		(tx_buf_wr_in && !tx_en_r && !tx_pend_r) |=> !tx_pend_r;
	endproperty
	a_tx_drop: assert property (p_tx_drop) else $error("disabled write became pending");

	property p_tx_finish;
		(tx_act_r && tx_pend_r && tx_shifter_idle_in && !tx_load_out && susp_r == SUSP_RUN) |=> tx_load_out;
	endproperty
	a_tx_finish: assert property (p_tx_finish) else $error("ongoing frame data not loaded");

	property p_rx_store;
		rx_char_done_in |=> (rx_store_out == $past(rx_en_r));
	endproperty
	a_rx_store: assert property (p_rx_store) else $error("receive hand-off not gated by enable");

	property p_rx_quiet;
		(!rx_en_r && !irq_sts[IRQ_RX_ERR] && !irq_sts[IRQ_RX_STOR]) |=>
			(!rx_flag_upd_out && !irq_sts[IRQ_RX_ERR] && !irq_sts[IRQ_RX_STOR]);
	endproperty
	a_rx_quiet: assert property (p_rx_quiet) else $error("receive activity while disabled");

	property p_flag_ok;
		rx_frame_start_in |=> (rx_flag_valid_out == $past(rx_en_r));
	endproperty
	a_flag_ok: assert property (p_flag_ok) else $error("flag validity not taken at frame start");

	property p_cnt_run;
		(!debug_halt_in || ros_r) |=> cnt_run_out;
	endproperty
	a_cnt_run: assert property (p_cnt_run) else $error("counters stopped outside freeze");

	property p_cnt_stop;
		(debug_halt_in && !ros_r) |=> (!cnt_run_out && freeze_out);
	endproperty
	a_cnt_stop: assert property (p_cnt_stop) else $error("halt without continue did not stop");

	property p_frozen_hold;
		(susp_r == SUSP_FROZEN) |=> !tx_load_out;
	endproperty
	a_frozen_hold: assert property (p_frozen_hold) else $error("transmit load while frozen");

	property p_drain;
		(debug_halt_in && ros_r && (tx_act_r || rx_act_r) && susp_r != SUSP_FROZEN) |=> !freeze_out;
	endproperty
	a_drain: assert property (p_drain) else $error("froze before current frame finished");
endmodule // lpe_ctrl

// File: lpe_peer.sv
/*
 * lpe_peer: behavioural transmit shifter and line peer for the path enable bench.
 * assumes tx_load_in is a one-cycle pulse on mclk_in; a frame is FRAME_LEN bytes, checksum last.
 */
`timescale 1ns/10ps
module lpe_peer #(
	parameter int BUSY_CYC  = 20,
	parameter int FRAME_LEN = 2
) (
	// clock and reset
	input  wire logic mclk_in,
	input  wire logic rst_in,
	// shifter side
	input  wire logic tx_load_in,
	output logic      tx_shifter_idle_out,
	output logic      tx_frame_done_out
);
	int busy_r;
	int nbyte_r;

	// slow on purpose, so software can change the enable while a byte is still on the line
	assign tx_shifter_idle_out = (busy_r == 0) && !tx_load_in;

	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			busy_r            <= 0;
			nbyte_r           <= 0;
			tx_frame_done_out <= 1'b0;
		end else begin
			tx_frame_done_out <= 1'b0;
			if (tx_load_in) begin
				busy_r <= BUSY_CYC;
			end else if (busy_r > 0) begin
				busy_r <= busy_r - 1;
			end
			if (!tx_load_in && busy_r == 1) begin
				if (nbyte_r + 1 == FRAME_LEN) begin
					tx_frame_done_out <= 1'b1;
					nbyte_r           <= 0;
				end else begin
					nbyte_r <= nbyte_r + 1;
				end
			end
		end
	end
endmodule // lpe_peer

// File: lpe_pkg.sv
/*
 * lpe_pkg: register map, field positions, reset values and shared types of the path enable control block.
 * assumes a 32-bit AXI4-Lite register bus with 12-bit byte addresses.
 */
package lpe_pkg;
	localparam int          ADDR_W      = 12;
	localparam int          DATA_W      = 32;
	localparam int          STRB_W      = 4;
	// register byte addresses
	localparam logic [11:0] OFS_GC1     = 12'h000;
	localparam logic [11:0] OFS_IRQ_STS = 12'h004;
	localparam logic [11:0] OFS_IRQ_MSK = 12'h008;
	localparam logic [11:0] OFS_PATH    = 12'h00c;
	// global_control_one fields
	localparam int          TX_EN_BIT   = 25;
	localparam int          RX_EN_BIT   = 24;
	localparam int          ROS_BIT     = 17;
	localparam logic [31:0] GC1_WMASK   = 32'h0302_0000;
	localparam logic        TX_EN_RST   = 1'h0;
	localparam logic        RX_EN_RST   = 1'h0;
	localparam logic        ROS_RST     = 1'h0;
	// interrupt status and mask layout
	localparam int          IRQ_W       = 4;
	localparam int          IRQ_TX_LOAD = 0;
	localparam int          IRQ_RX_STOR = 1;
	localparam int          IRQ_RX_ERR  = 2;
	localparam int          IRQ_LATE_EN = 3;
	localparam logic [3:0]  IRQ_MSK_RST = 4'h0;
	// path state readback layout
	localparam int          PS_TX_PEND  = 0;
	localparam int          PS_TX_ACT   = 1;
	localparam int          PS_RX_ACT   = 2;
	localparam int          PS_FREEZE   = 3;
	localparam int          PS_FLAG_OK  = 4;
	localparam int          PS_CNT_RUN  = 5;
	// bus responses
	localparam logic [1:0]  RESP_OKAY   = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		SUSP_RUN,
		SUSP_DRAIN,
		SUSP_FROZEN
	} lpe_susp_e;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
		logic [STRB_W-1:0] strb;
	} lpe_wr_s;

	function automatic logic lpe_addr_hit(input logic [ADDR_W-1:0] a);
		return (a[11:2] == OFS_GC1[11:2]) || (a[11:2] == OFS_IRQ_STS[11:2]) ||
		       (a[11:2] == OFS_IRQ_MSK[11:2]) || (a[11:2] == OFS_PATH[11:2]);
	endfunction
endpackage

// File: lpe_w1c.sv
/*
 * lpe_w1c: a row of sticky event bits, cleared by writing one.
 * assumes set and clear pulses synchronous to mclk_in.
 */
`timescale 1ns/10ps
module lpe_w1c #(
	parameter int W = 4
) (
	// clock and reset
	input  wire logic         mclk_in,
	input  wire logic         rst_in,
	// events and clears
	input  wire logic [W-1:0] set_in,
	input  wire logic [W-1:0] clr_in,
	// sticky state
	output logic      [W-1:0] q_out
);
	import lpe_pkg::*;

	// set wins so an event in the clearing cycle is kept
	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			q_out <= '0;
		end else begin
			q_out <= (q_out & ~clr_in) | set_in;
		end
	end
endmodule // lpe_w1c
